// File: src/acc_defines.svh
// Register offsets, field positions, reset values and timing counts of the comparator control.
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH

`define ACC_OFF_CTRL_STATUS   12'h030
`define ACC_OFF_CONV_STATUS_B 12'h034
`define ACC_OFF_DIG_DISABLE   12'h038
`define ACC_OFF_HOST_CTRL     12'h03c
`define ACC_OFF_IRQ_STATUS    12'h040
`define ACC_OFF_IRQ_MASK      12'h044

`define ACC_BIT_POWER_OFF     7
`define ACC_BIT_BANDGAP       6
`define ACC_BIT_RESULT        5
`define ACC_BIT_EVENT_FLAG    4
`define ACC_BIT_IRQ_ENABLE    3
`define ACC_BIT_CAPTURE       2
`define ACC_BIT_MODE_HI       1
`define ACC_BIT_MODE_LO       0
`define ACC_BIT_MUX_ENABLE    6
`define ACC_BIT_NEG_BUF_OFF   1
`define ACC_BIT_POS_BUF_OFF   0
`define ACC_BIT_CONV_ENABLE   0
`define ACC_BIT_GLOBAL_IE     1
`define ACC_BIT_CONV_PWR_RED  2

`define ACC_CTRL_RESET        8'h00
`define ACC_CTRL_WMASK        8'hdf
`define ACC_CONVB_WMASK       8'h40
`define ACC_DIDR_WMASK        8'h03
`define ACC_HOST_WMASK        8'h07
`define ACC_SYNC_STAGES       2
`define ACC_RESP_OKAY         2'b00
`define ACC_RESP_SLVERR       2'b10

`endif

// File: src/acc_pkg.sv
// Types shared by the comparator control modules.
package acc_pkg;
  typedef enum logic [1:0] {
    ACC_MODE_TOGGLE   = 2'b00,
    ACC_MODE_RESERVED = 2'b01,
    ACC_MODE_FALLING  = 2'b10,
    ACC_MODE_RISING   = 2'b11
  } acc_mode_e;
  typedef logic [7:0] acc_byte_t;
endpackage : acc_pkg

// File: src/acc_sync.sv
// Two-stage synchroniser for a level from the analog core.
`timescale 1ns/1ps
module acc_sync #(
  parameter int STAGES = 2
) (
  // Clock and reset.
  input  wire logic sys_clk_in,
  input  wire logic reset_n_in,
  // Level in and out.
  input  wire logic async_in,
  output logic      sync_out
);
  import acc_pkg::*;

  logic [STAGES-1:0] chain;

  initial begin
    if (STAGES < 2) begin
      $error("acc_sync needs at least two stages");
    end
  end

  // Shift the level through the chain; only the last stage is read.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      chain <= '0;
    end else begin
      chain <= {chain[STAGES-2:0], async_in};
    end
  end

  assign sync_out = chain[STAGES-1];
endmodule : acc_sync

// File: src/acc_edge.sv
// Event detector choosing toggle, falling or rising edge of the synced result.
`timescale 1ns/1ps
module acc_edge (
  // Clock and reset.
  input  wire logic                sys_clk_in,
  input  wire logic                reset_n_in,
  // Level and mode.
  input  wire logic                level_in,
  input  wire acc_pkg::acc_mode_e  mode_in,
  // Event pulse and previous level.
  output logic                     event_out,
  output logic                     prev_out
);
  import acc_pkg::*;

  logic prev;

  // Remember the level of the previous clock.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prev <= 1'b0;
    end else begin
      prev <= level_in;
    end
  end

  // Match the edge against the selected mode.
  always_comb begin
    case (mode_in)
      ACC_MODE_TOGGLE:  event_out = level_in ^ prev;
      ACC_MODE_FALLING: event_out = prev & ~level_in;
      ACC_MODE_RISING:  event_out = ~prev & level_in;
      default:          event_out = 1'b0;
    endcase
  end

  assign prev_out = prev;
endmodule : acc_edge

// File: src/acc_top.sv
// Analog comparator control: input selection, result sync, events, interrupt and AXI4-Lite registers.
`timescale 1ns/1ps
`include "acc_defines.svh"
module acc_top #(
  parameter int ADDR_W = 12
) (
  // Clock and reset.
  input  wire logic              sys_clk_in,
  input  wire logic              reset_n_in,
  // AXI4-Lite write address.
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  // AXI4-Lite write data.
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  // AXI4-Lite write response.
  output logic [1:0]             s_axi_bresp_out,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  // AXI4-Lite read address.
  input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  // AXI4-Lite read data.
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  // Analog core: raw compare and selections.
  input  wire logic              raw_compare_in,
  output logic                   cmp_power_off_out,
  output logic                   bandgap_select_out,
  output logic                   neg_from_mux_out,
  output logic [2:0]             neg_channel_out,
  // Digital input buffers of the two pins.
  input  wire logic              positive_input_pin_in,
  input  wire logic              negative_input_pin_in,
  output logic                   positive_pin_buffer_off_out,
  output logic                   negative_pin_buffer_off_out,
  output logic                   positive_pin_port_out,
  output logic                   negative_pin_port_out,
  // Converter and processor context.
  input  wire logic              converter_enable_in,
  input  wire logic [2:0]        channel_select_in,
  input  wire logic              vector_taken_in,
  // Timer capture and interrupts.
  output logic                   capture_source_out,
  output logic                   capture_route_out,
  output logic                   cmp_irq_out,
  output logic                   irq_out
);
  import acc_pkg::*;

  initial begin
    if (ADDR_W < 8) begin
      $error("acc_top needs at least 8 address bits");
    end
  end

  // Control state.
  logic       cmp_power_off;
  logic       bandgap_select;
  logic       cmp_event_flag;
  logic       cmp_irq_enable;
  logic       cmp_capture_route;
  acc_mode_e  cmp_event_mode;
  logic       cmp_mux_enable;
  logic       positive_pin_buffer_off;
  logic       negative_pin_buffer_off;
  logic       global_ie;
  logic       converter_power_reduce;
  logic       host_conv_enable;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  // Result path.
  logic       result_sync;
  logic       cmp_result;
  logic       event_pulse;
  logic       prev_result;
  // Bus state.
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              wr_fire;
  logic              flag_clr_write;
  logic [7:0]        wbyte;
  logic [31:0]       next_rdata;
  logic              next_rhit;
  logic              conv_on;
  logic [11:0]       aw_off;
  logic [11:0]       ar_off;

  // While powered off the core output is ignored and held low.
  acc_sync #(.STAGES(`ACC_SYNC_STAGES)) u_sync (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .async_in   (raw_compare_in & ~cmp_power_off),
    .sync_out   (result_sync)
  );
  assign cmp_result = result_sync;

  acc_edge u_edge (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .level_in   (cmp_result),
    .mode_in    (cmp_event_mode),
    .event_out  (event_pulse),
    .prev_out   (prev_result)
  );

  // Either the bus bit or the converter's own enable counts as converter on.
  assign conv_on = converter_enable_in | host_conv_enable;

  // Decode on the low address byte, widened to the width of the offset constants.
  assign aw_off = {4'h0, aw_addr[7:0]};
  assign ar_off = {4'h0, s_axi_araddr_in[7:0]};
  assign wr_fire = aw_held & w_held & ~s_axi_bvalid_out;
  assign wbyte = w_data[7:0];
  assign flag_clr_write = wr_fire & w_strb[0] & (aw_off == `ACC_OFF_CTRL_STATUS)
                          & wbyte[`ACC_BIT_EVENT_FLAG];

  // Write address and data are taken independently, response follows both.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_in;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // Ready pulses for one cycle when a channel slot is empty.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
    end else begin
      s_axi_awready_out <= ~aw_held & ~s_axi_awready_out & s_axi_awvalid_in
                           & ~s_axi_bvalid_out;
      s_axi_wready_out  <= ~w_held & ~s_axi_wready_out & s_axi_wvalid_in
                           & ~s_axi_bvalid_out;
    end
  end

  // Write response.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= `ACC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_out <= 1'b1;
      case (aw_off)
        `ACC_OFF_CTRL_STATUS, `ACC_OFF_CONV_STATUS_B, `ACC_OFF_DIG_DISABLE,
        `ACC_OFF_HOST_CTRL, `ACC_OFF_IRQ_STATUS, `ACC_OFF_IRQ_MASK:
          s_axi_bresp_out <= `ACC_RESP_OKAY;
        default: s_axi_bresp_out <= `ACC_RESP_SLVERR;
      endcase
    end else if (s_axi_bvalid_out && s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // Writable control bits, all cleared at reset.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmp_power_off           <= 1'b0;
      bandgap_select          <= 1'b0;
      cmp_irq_enable          <= 1'b0;
      cmp_capture_route       <= 1'b0;
      cmp_event_mode          <= ACC_MODE_TOGGLE;
      cmp_mux_enable          <= 1'b0;
      positive_pin_buffer_off <= 1'b0;
      negative_pin_buffer_off <= 1'b0;
      global_ie               <= 1'b0;
      host_conv_enable        <= 1'b0;
      converter_power_reduce  <= 1'b0;
      irq_mask                <= 2'b00;
    end else if (wr_fire && w_strb[0]) begin
      case (aw_off)
        `ACC_OFF_CTRL_STATUS: begin
          cmp_power_off     <= wbyte[`ACC_BIT_POWER_OFF];
          bandgap_select    <= wbyte[`ACC_BIT_BANDGAP];
          cmp_irq_enable    <= wbyte[`ACC_BIT_IRQ_ENABLE];
          cmp_capture_route <= wbyte[`ACC_BIT_CAPTURE];
          cmp_event_mode    <= acc_mode_e'(wbyte[`ACC_BIT_MODE_HI:`ACC_BIT_MODE_LO]);
        end
        `ACC_OFF_CONV_STATUS_B: cmp_mux_enable <= wbyte[`ACC_BIT_MUX_ENABLE];
        `ACC_OFF_DIG_DISABLE: begin
          positive_pin_buffer_off <= wbyte[`ACC_BIT_POS_BUF_OFF];
          negative_pin_buffer_off <= wbyte[`ACC_BIT_NEG_BUF_OFF];
        end
        `ACC_OFF_HOST_CTRL: begin
          host_conv_enable       <= wbyte[`ACC_BIT_CONV_ENABLE];
          global_ie              <= wbyte[`ACC_BIT_GLOBAL_IE];
          converter_power_reduce <= wbyte[`ACC_BIT_CONV_PWR_RED];
        end
        `ACC_OFF_IRQ_MASK: irq_mask <= wbyte[1:0];
        default: ;
      endcase
    end
  end

  // Event flag: a new event wins over a clear in the same cycle.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmp_event_flag <= 1'b0;
    end else if (event_pulse) begin
      cmp_event_flag <= 1'b1;
    end else if (vector_taken_in && cmp_irq_out) begin
      cmp_event_flag <= 1'b0;
    end else if (flag_clr_write) begin
      cmp_event_flag <= 1'b0;
    end
  end

  // Sticky status: bit0 event, bit1 result rise; write one to clear.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_status <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == 0 && event_pulse) || (i == 1 && cmp_result && !prev_result)) begin
          irq_status[i] <= 1'b1;
        end else if (wr_fire && w_strb[0] && aw_off == `ACC_OFF_IRQ_STATUS
                     && wbyte[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
    end
  end

  // Analog selections and pin gating, all registered.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmp_power_off_out           <= 1'b0;
      bandgap_select_out          <= 1'b0;
      neg_from_mux_out            <= 1'b0;
      neg_channel_out             <= 3'h0;
      positive_pin_buffer_off_out <= 1'b0;
      negative_pin_buffer_off_out <= 1'b0;
      positive_pin_port_out       <= 1'b0;
      negative_pin_port_out       <= 1'b0;
      capture_source_out          <= 1'b0;
      capture_route_out           <= 1'b0;
      cmp_irq_out                 <= 1'b0;
      irq_out                     <= 1'b0;
    end else begin
      cmp_power_off_out  <= cmp_power_off;
      bandgap_select_out <= bandgap_select;
      neg_from_mux_out   <= cmp_mux_enable & ~conv_on;
      neg_channel_out    <= (cmp_mux_enable & ~conv_on) ? channel_select_in : 3'h0;
      positive_pin_buffer_off_out <= positive_pin_buffer_off;
      negative_pin_buffer_off_out <= negative_pin_buffer_off;
      positive_pin_port_out <= positive_input_pin_in & ~positive_pin_buffer_off;
      negative_pin_port_out <= negative_input_pin_in & ~negative_pin_buffer_off;
      capture_source_out <= cmp_capture_route & cmp_result;
      capture_route_out  <= cmp_capture_route;
      cmp_irq_out <= (cmp_event_flag | event_pulse) & cmp_irq_enable & global_ie
                     & ~(vector_taken_in & cmp_irq_out);
      irq_out     <= |(irq_status & irq_mask);
    end
  end

  // Read data mux.
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rhit  = 1'b1;
    case (ar_off)
      `ACC_OFF_CTRL_STATUS: next_rdata[7:0] = {cmp_power_off, bandgap_select, cmp_result,
                                               cmp_event_flag, cmp_irq_enable,
                                               cmp_capture_route, cmp_event_mode};
      `ACC_OFF_CONV_STATUS_B: next_rdata[`ACC_BIT_MUX_ENABLE] = cmp_mux_enable;
      `ACC_OFF_DIG_DISABLE: next_rdata[1:0] = {negative_pin_buffer_off,
                                               positive_pin_buffer_off};
      `ACC_OFF_HOST_CTRL: next_rdata[2:0] = {converter_power_reduce, global_ie,
                                             host_conv_enable};
      `ACC_OFF_IRQ_STATUS: next_rdata[1:0] = irq_status;
      `ACC_OFF_IRQ_MASK: next_rdata[1:0] = irq_mask;
      default: next_rhit = 1'b0;
    endcase
  end

  // Read channel: one-cycle arready, data the cycle after.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= `ACC_RESP_OKAY;
    end else begin
      s_axi_arready_out <= s_axi_arvalid_in & ~s_axi_arready_out & ~s_axi_rvalid_out;
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out  <= next_rdata;
        s_axi_rresp_out  <= next_rhit ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end
endmodule : acc_top

// File: testbench/acc_assertions.sv
// Concurrent checks on the ports of the comparator control top level.
`timescale 1ns/1ps
module acc_assertions #(
  parameter int ADDR_W = 12
) (
  // Clock and reset.
  input wire logic       sys_clk_in,
  input wire logic       reset_n_in,
  // Bus handshakes.
  input wire logic       s_axi_awvalid_in,
  input wire logic       s_axi_awready_out,
  input wire logic       s_axi_bvalid_out,
  input wire logic       s_axi_arvalid_in,
  input wire logic       s_axi_arready_out,
  input wire logic       s_axi_rvalid_out,
  // Input selection and context.
  input wire logic       neg_from_mux_out,
  input wire logic [2:0] neg_channel_out,
  input wire logic       converter_enable_in,
  input wire logic [2:0] channel_select_in,
  input wire logic       vector_taken_in,
  // Interrupt, capture and pin outputs.
  input wire logic       cmp_irq_out,
  input wire logic       capture_route_out,
  input wire logic       capture_source_out,
  input wire logic       positive_pin_buffer_off_out,
  input wire logic       positive_pin_port_out
);
  // All checks run on the system clock and sleep through reset.
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  a_port_forced_low: assert property (
    $past(positive_pin_buffer_off_out) && positive_pin_buffer_off_out |-> !positive_pin_port_out)
    else $error("Port bit not forced low with buffer off.");
  a_capture_cut_off: assert property (
    !capture_route_out && $past(capture_route_out) == 1'b0 |-> !capture_source_out)
    else $error("Capture source active without routing.");
  a_vector_clears_irq: assert property (
    vector_taken_in |-> ##[1:3] !cmp_irq_out)
    else $error("Vector did not drop the comparator request.");
  a_channel_idle_zero: assert property (
    !neg_from_mux_out |-> neg_channel_out == 3'h0)
    else $error("Channel output set while pin feeds negative input.");
  a_converter_owns_mux: assert property (
    converter_enable_in && $past(converter_enable_in) |-> !neg_from_mux_out)
    else $error("Mux feeds comparator while converter is on.");
  a_channel_follows: assert property (
    neg_from_mux_out |-> neg_channel_out == $past(channel_select_in))
    else $error("Routed channel differs from selected channel.");
  a_read_answer: assert property (
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("Read data did not follow the address handshake.");
  a_write_answer: assert property (
    s_axi_awvalid_in && s_axi_awready_out |-> ##[1:3] s_axi_bvalid_out)
    else $error("Write response late.");
endmodule : acc_assertions

// File: testbench/acc_core_model.sv
// Behavioural analog comparator core with its input pins and reference.
`timescale 1ns/1ps
module acc_core_model #(
  parameter logic [7:0] BANDGAP_MV = 8'h80
) (
  // Selections from the control block.
  input  wire logic       power_off_in,
  input  wire logic       bandgap_in,
  input  wire logic       from_mux_in,
  input  wire logic [2:0] channel_in,
  // Pin levels set by the bench.
  input  wire logic [7:0] pos_mv_in,
  input  wire logic [7:0] neg_mv_in,
  // Raw compare result.
  output logic            raw_out
);
  logic [7:0] plus_mv;
  logic [7:0] minus_mv;
  // Positive side is the reference or the pin; converter pin N sits at 16*N+8.
  assign plus_mv  = bandgap_in ? BANDGAP_MV : pos_mv_in;
  assign minus_mv = from_mux_in ? {1'b0, channel_in, 4'h8} : neg_mv_in;
  // An unpowered comparator holds its output low.
  assign raw_out = !power_off_in && (plus_mv > minus_mv);
endmodule : acc_core_model

// File: testbench/testbench.sv
// Self-checking bench for the comparator control block.
`timescale 1ns/1ps
`include "acc_defines.svh"
module testbench;
  localparam logic [11:0] ctl_addr  = `ACC_OFF_CTRL_STATUS;
  localparam logic [11:0] conv_addr = `ACC_OFF_CONV_STATUS_B;
  localparam logic [11:0] dig_addr  = `ACC_OFF_DIG_DISABLE;
  localparam logic [11:0] host_addr = `ACC_OFF_HOST_CTRL;
  localparam logic [11:0] ists_addr = `ACC_OFF_IRQ_STATUS;
  localparam logic [11:0] imsk_addr = `ACC_OFF_IRQ_MASK;
  logic        sys_clk_in, reset_n_in;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_data;
  logic [1:0]  bresp, rresp, rd_resp, wr_resp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, raw, pwr_off, bg_sel, from_mux;
  logic [2:0]  neg_ch, chan;
  logic        pos_pin, neg_pin, pos_off, neg_off, pos_port, neg_port, conv_en, vec;
  logic        cap_src, cap_route, cmp_irq, irq;
  logic [7:0]  pos_mv;
  int          errors, compares, cycles;

  // Design under test and the analog core beside it.
  acc_top #(.ADDR_W(12)) u_dut (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'h1), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .raw_compare_in(raw),
    .cmp_power_off_out(pwr_off), .bandgap_select_out(bg_sel), .neg_from_mux_out(from_mux),
    .neg_channel_out(neg_ch), .positive_input_pin_in(pos_pin), .negative_input_pin_in(neg_pin),
    .positive_pin_buffer_off_out(pos_off), .negative_pin_buffer_off_out(neg_off),
    .positive_pin_port_out(pos_port), .negative_pin_port_out(neg_port),
    .converter_enable_in(conv_en), .channel_select_in(chan), .vector_taken_in(vec),
    .capture_source_out(cap_src), .capture_route_out(cap_route), .cmp_irq_out(cmp_irq),
    .irq_out(irq)
  );
  acc_core_model u_core (
    .power_off_in(pwr_off), .bandgap_in(bg_sel), .from_mux_in(from_mux), .channel_in(neg_ch),
    .pos_mv_in(pos_mv), .neg_mv_in(8'h40), .raw_out(raw)
  );

  // Free-running system clock.
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("Comparisons %0d, errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge sys_clk_in);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    @(posedge sys_clk_in);
    while (awvalid || wvalid) begin
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      @(posedge sys_clk_in);
    end
    while (!bvalid) @(posedge sys_clk_in);
    wr_resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(posedge sys_clk_in);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    @(posedge sys_clk_in);
    while (!arready) @(posedge sys_clk_in);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge sys_clk_in);
    rd_data = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
    rd(a);
    check(rd_resp, `ACC_RESP_OKAY);
    check(rd_data & m, exp);
  endtask : rchk

  // Cut a hung run short.
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end

  // Main sequence.
  initial begin
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    {pos_pin, neg_pin, conv_en, chan, vec} = '0;
    pos_mv = 8'h20;
    reset_n_in = 1'b0;
    repeat (12) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    rchk(ctl_addr, 32'h0, 32'hdf);
    rchk(conv_addr, 32'h0, 32'hff);
    wr(ctl_addr, 32'h30);
    rchk(ctl_addr, 32'h0, 32'hff);
    wr(12'h0fc, 32'hff);
    check(wr_resp, `ACC_RESP_SLVERR);
    rd(12'h0fc);
    check(rd_resp, `ACC_RESP_SLVERR);
    check(rd_data, 32'h0);
    // Negative input from every converter pin, then back to the dedicated pin.
    wr(conv_addr, 32'h40);
    pos_mv <= 8'h40;
    for (int ch = 0; ch < 8; ch++) begin
      chan <= ch[2:0];
      repeat (6) @(posedge sys_clk_in);
      check(from_mux, 1);
      check(neg_ch, ch);
      rchk(ctl_addr, (ch < 4) ? 32'h20 : 32'h0, 32'h20);
    end
    conv_en <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    check(from_mux, 0);
    conv_en <= 1'b0;
    wr(host_addr, 32'h1);
    repeat (4) @(posedge sys_clk_in);
    check(from_mux, 0);
    wr(host_addr, 32'h0);
    wr(conv_addr, 32'h0);
    repeat (4) @(posedge sys_clk_in);
    check(from_mux, 0);
    // Every event mode against a rise and a fall.
    for (int m = 0; m < 4; m++) begin
      pos_mv <= 8'h20;
      repeat (6) @(posedge sys_clk_in);
      wr(ctl_addr, 32'h10 | m);
      rchk(ctl_addr, m, 32'h3f);
      pos_mv <= 8'h60;
      repeat (6) @(posedge sys_clk_in);
      rchk(ctl_addr, (m == 0 || m == 3) ? 32'h30 : 32'h20, 32'h30);
      wr(ctl_addr, m);
      rchk(ctl_addr, (m == 0 || m == 3) ? 32'h30 : 32'h20, 32'h30);
      wr(ctl_addr, 32'h10 | m);
      pos_mv <= 8'h20;
      repeat (6) @(posedge sys_clk_in);
      rchk(ctl_addr, (m == 0 || m == 2) ? 32'h10 : 32'h0, 32'h30);
    end
    // Request gating, status and mask, and the vector clear.
    wr(ists_addr, 32'h3);
    wr(ctl_addr, 32'h1b);
    pos_mv <= 8'h60;
    repeat (6) @(posedge sys_clk_in);
    check(cmp_irq, 0);
    rchk(ctl_addr, 32'h10, 32'h10);
    wr(host_addr, 32'h2);
    repeat (3) @(posedge sys_clk_in);
    check(cmp_irq, 1);
    rchk(ists_addr, 32'h3, 32'h3);
    check(irq, 0);
    wr(imsk_addr, 32'h1);
    repeat (2) @(posedge sys_clk_in);
    check(irq, 1);
    wr(ists_addr, 32'h1);
    repeat (2) @(posedge sys_clk_in);
    check(irq, 0);
    rchk(ists_addr, 32'h2, 32'h3);
    vec <= 1'b1;
    @(posedge sys_clk_in);
    vec <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    check(cmp_irq, 0);
    rchk(ctl_addr, 32'h0, 32'h10);
    wr(host_addr, 32'h0);
    // Capture routing on and off.
    wr(ctl_addr, 32'h04);
    repeat (3) @(posedge sys_clk_in);
    check({cap_route, cap_src}, 2'b11);
    pos_mv <= 8'h20;
    @(posedge sys_clk_in);
    check(cap_src, 1);
    repeat (5) @(posedge sys_clk_in);
    check(cap_src, 0);
    pos_mv <= 8'h60;
    wr(ctl_addr, 32'h0);
    repeat (6) @(posedge sys_clk_in);
    check(cap_src, 0);
    // Bandgap reference and power off.
    pos_mv <= 8'h20;
    wr(ctl_addr, 32'h40);
    repeat (6) @(posedge sys_clk_in);
    check(bg_sel, 1);
    rchk(ctl_addr, 32'h60, 32'he0);
    wr(ctl_addr, 32'hc0);
    repeat (6) @(posedge sys_clk_in);
    check(pwr_off, 1);
    rchk(ctl_addr, 32'hc0, 32'he0);
    wr(ctl_addr, 32'h0);
    // Digital input buffers of both pins.
    pos_pin <= 1'b1;
    neg_pin <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(dig_addr, k);
      repeat (3) @(posedge sys_clk_in);
      rchk(dig_addr, k, 32'hff);
      check({pos_off, neg_off}, {k[0], k[1]});
      check({pos_port, neg_port}, {~k[0], ~k[1]});
    end
    conclude();
  end
endmodule : testbench

bind acc_top acc_assertions #(.ADDR_W(ADDR_W)) u_acc_assertions (
  .sys_clk_in, .reset_n_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_bvalid_out,
  .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out, .neg_from_mux_out,
  .neg_channel_out, .converter_enable_in, .channel_select_in, .vector_taken_in,
  .cmp_irq_out, .capture_route_out, .capture_source_out, .positive_pin_buffer_off_out,
  .positive_pin_port_out
);
